// ### verilog/rpw_top.sv
// RTC pin and wake-up control: access gate, clock-output pin and wake pin
// How it works
// - The RTC timebase is the 32.768 kHz crystal clock, a domain separate from the system clock.
// - While the RTC oscillator is stopped, accesses to the RTC I/O window 1900h-197Fh are refused.
// - The clock output pin is driven only while the clock output enable bit of the power register is set.
// - After reset the clock output pin is undriven until software sets the enable bit.
// - With the wake pin as input, a high level on it raises a wake request to the CPU core.
// - On RTC supply power-up the wake pin is an input.
// - As output the wake pin is active-low open drain, pulled low on an RTC alarm.
`timescale 1ns/1ps
`include "rpw_consts.svh"
module rpw_top
	import rpw_pkg::*;
(
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	// RTC crystal clock, sampled as a level
	input  wire logic        i_rtc_xtal_clk,
	input  wire logic        i_rtc_osc_enable,
	// I/O access from the CPU
	input  wire logic        i_io_req,
	input  wire logic [15:0] i_io_addr,
	output logic             o_io_grant,
	output logic             o_io_block,
	// Power management register bits
	input  wire logic        i_clock_output_enable_bit,
	input  wire logic        i_wake_output_mode,
	// Alarm from the calendar
	input  wire logic        i_rtc_alarm_pending,
	// Clock output pin
	output logic             o_rtc_clock_output_pin,
	output logic             o_rtc_clock_output_pin_oe,
	// Wake pin, open drain
	input  wire logic        i_wake_pin,
	output logic             o_wake_pin,
	output logic             o_wake_pin_oe,
	// Wake request to the CPU core and oscillator running status
	output logic             o_core_wake_req,
	output logic             o_osc_running
);
	typedef struct packed
	{
		rpw_osc_type          osc;
		logic [`RPW_CNT_W-1:0] loss_cnt;
		logic                 xtal_prev;
		logic                 io_grant;
		logic                 io_block;
		logic                 clk_out;
		logic                 clk_oe;
		rpw_wake_mode_type    wake_mode;
		logic                 wake_oe;
		logic                 core_wake;
		logic                 osc_run;
	} rpw_state_type;

	localparam logic [`RPW_CNT_W-1:0] LOSS_MAX = `RPW_CNT_W'(`RPW_OSC_LOSS_CYC - 1);

	rpw_state_type st_reg;
	rpw_state_type st_next;
	logic          xtal_sync;
	logic          wake_sync;
	logic          in_window;
	logic          xtal_edge;

	// Crystal clock is far slower than the system clock, so it is sampled
	rpw_sync u_xtal_sync
	(
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_d       (i_rtc_xtal_clk),
		.o_q       (xtal_sync)
	);

	rpw_sync u_wake_sync
	(
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_d       (i_wake_pin),
		.o_q       (wake_sync)
	);

	assign in_window = (i_io_addr >= `RPW_WIN_LO) && (i_io_addr <= `RPW_WIN_HI);
	assign xtal_edge = xtal_sync && !st_reg.xtal_prev;

	always_comb
	begin
		st_next           = st_reg;
		st_next.xtal_prev = xtal_sync;
		// Oscillator counts as running only while enabled and toggling
		unique case (st_reg.osc)
			RPW_OSC_STOPPED:
			begin
				if (i_rtc_osc_enable && xtal_edge)
				begin
					st_next.osc      = RPW_OSC_RUNNING;
					st_next.loss_cnt = '0;
				end
			end
			RPW_OSC_RUNNING:
			begin
				if (xtal_edge)
					st_next.loss_cnt = '0;
				else if (st_reg.loss_cnt != LOSS_MAX)
					st_next.loss_cnt = st_reg.loss_cnt + 1'b1;
				if (!i_rtc_osc_enable || st_reg.loss_cnt == LOSS_MAX)
					st_next.osc = RPW_OSC_STOPPED;
			end
			default:
				st_next.osc = RPW_OSC_STOPPED;
		endcase
		// Accesses outside the window pass regardless of the oscillator
		st_next.io_grant = i_io_req && (!in_window || st_reg.osc == RPW_OSC_RUNNING);
		st_next.io_block = i_io_req && in_window && st_reg.osc != RPW_OSC_RUNNING;
		st_next.clk_oe   = i_clock_output_enable_bit;
		st_next.clk_out  = i_clock_output_enable_bit && xtal_sync;
		st_next.wake_mode = i_wake_output_mode ? RPW_WAKE_OUTPUT : RPW_WAKE_INPUT;
		// Pin only ever pulls low; the board pull-up makes the high level
		st_next.wake_oe   = i_wake_output_mode && i_rtc_alarm_pending;
		st_next.core_wake = !i_wake_output_mode && wake_sync;
		// Kept as its own flop so the status output has no decode behind it
		st_next.osc_run   = (st_next.osc == RPW_OSC_RUNNING);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			st_reg           <= '0;
			st_reg.osc       <= RPW_OSC_STOPPED;
			st_reg.clk_oe    <= `RPW_CLKOUT_EN_RST;
			st_reg.wake_mode <= RPW_WAKE_INPUT;
			st_reg.wake_oe   <= `RPW_WAKE_OUT_RST;
		end
		else
			st_reg <= st_next;
	end

	assign o_io_grant                = st_reg.io_grant;
	assign o_io_block                = st_reg.io_block;
	assign o_rtc_clock_output_pin    = st_reg.clk_out;
	assign o_rtc_clock_output_pin_oe = st_reg.clk_oe;
	assign o_wake_pin                = 1'b0;
	assign o_wake_pin_oe             = st_reg.wake_oe;
	assign o_core_wake_req           = st_reg.core_wake;
	assign o_osc_running             = st_reg.osc_run;
endmodule

// ### pkg/rpw_consts.svh
// Constants for the RTC pin and wake-up control block
`ifndef RPW_CONSTS_SVH
`define RPW_CONSTS_SVH

// Register window that is blocked while the RTC oscillator is stopped
`define RPW_WIN_LO        16'h1900
`define RPW_WIN_HI        16'h197F
// Watch-crystal frequency in Hz
`define RPW_XTAL_HZ       32768
// System clock rate in MHz
`define RPW_SYS_MHZ       200
// Oscillator is declared stopped after this many ns without a crystal edge
`define RPW_OSC_LOSS_NS   100000
`define RPW_OSC_LOSS_CYC  ((`RPW_OSC_LOSS_NS * `RPW_SYS_MHZ) / 1000)
`define RPW_CNT_W         16
// Reset values
`define RPW_CLKOUT_EN_RST 1'b0
`define RPW_WAKE_OUT_RST  1'b0

`endif

// ### pkg/rpw_pkg.sv
// Types of the RTC pin and wake-up control block
package rpw_pkg;
	typedef enum logic [1:0] {RPW_OSC_STOPPED, RPW_OSC_RUNNING} rpw_osc_type;
	typedef enum logic [1:0] {RPW_WAKE_INPUT, RPW_WAKE_OUTPUT} rpw_wake_mode_type;
endpackage

// ### verilog/rpw_sync.sv
// Two-stage synchroniser for one level
`timescale 1ns/1ps
module rpw_sync
(
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	// Level
	input  wire logic i_d,
	output logic      o_q
);
	typedef struct packed
	{
		logic meta;
		logic q;
	} rpw_sync_type;

	rpw_sync_type s_reg;
	rpw_sync_type s_next;

	always_comb
	begin
		s_next      = s_reg;
		s_next.meta = i_d;
		s_next.q    = s_reg.meta;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign o_q = s_reg.q;
endmodule

// ### testbench/rpw_top_sva.sv
// Assertions for the RTC pin and wake-up control block
`timescale 1ns/1ps
module rpw_top_sva
(
	// Ports watched, all inputs here
	input wire logic i_ref_clk, i_rstn, i_io_req, i_clock_output_enable_bit, i_wake_output_mode,
	input wire logic i_rtc_alarm_pending, i_wake_pin, o_io_grant, o_io_block, o_rtc_clock_output_pin_oe,
	input wire logic o_wake_pin_oe, o_core_wake_req, o_osc_running, i_rtc_osc_enable,
	input wire logic [15:0] i_io_addr
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	wire win = i_io_addr >= 16'h1900 && i_io_addr <= 16'h197F;
	// Pin level needs the two sync stages plus the output flop
	sequence pin_in_s; (!i_wake_output_mode && i_wake_pin) [*3]; endsequence
	win_block_a: assert property (i_io_req && win && !o_osc_running |=> o_io_block) else $error("no block");
	io_grant_a: assert property (i_io_req && (!win || o_osc_running) |=> o_io_grant) else $error("no grant");
	clk_on_a: assert property (i_clock_output_enable_bit |=> o_rtc_clock_output_pin_oe) else $error("pin off");
	clk_off_a: assert property (!i_clock_output_enable_bit |=> !o_rtc_clock_output_pin_oe) else $error("pin on");
	core_wake_a: assert property (pin_in_s |=> o_core_wake_req) else $error("no wake");
	wake_idle_a: assert property (!i_wake_output_mode |=> !o_wake_pin_oe) else $error("pin driven");
	wake_pull_a: assert property (i_wake_output_mode && i_rtc_alarm_pending |=> o_wake_pin_oe) else $error("no pull");
	wake_free_a: assert property (!i_rtc_alarm_pending |=> !o_wake_pin_oe) else $error("pin held");
	osc_stop_a: assert property (!i_rtc_osc_enable |=> !o_osc_running) else $error("osc on");
endmodule
bind rpw_top rpw_top_sva rpw_top_sva_inst (.*);

// ### testbench/rpw_partner.sv
// Far side: watch crystal and pulled-up wake line
`timescale 1ns/1ps
module rpw_partner
(
	// Crystal enable, outside driver, pin enable; crystal and line
	input  wire logic i_run,
	input  wire logic i_low,
	input  wire logic i_oe,
	output logic      o_xtal,
	output logic      o_line
);
	initial o_xtal = 1'b0;
	always #15259 o_xtal = i_run & ~o_xtal;
	// Pull-up wins once everyone lets go
	assign o_line = !(i_oe | i_low);
endmodule

// ### testbench/test_rpw_top.sv
// Bench for the RTC pin and wake-up control block
`timescale 1ns/1ps
module test_rpw_top;
	logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_rtc_xtal_clk, i_rtc_osc_enable, i_io_req, i_clock_output_enable_bit;
	logic low, i_wake_output_mode, i_rtc_alarm_pending, i_wake_pin, o_io_grant, o_io_block, o_rtc_clock_output_pin;
	logic o_rtc_clock_output_pin_oe, o_wake_pin, o_wake_pin_oe, o_core_wake_req, o_osc_running;
	logic [15:0] i_io_addr;
	logic [4:0] ctl = 5'h01;
	logic [16:0] rq = 17'h0;
	int err_count, comparisons, cyc;
	assign {i_rtc_osc_enable, i_clock_output_enable_bit, i_wake_output_mode, i_rtc_alarm_pending, low} = ctl;
	assign {i_io_req, i_io_addr} = rq;
	rpw_top rpw_top_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_rtc_xtal_clk(i_rtc_xtal_clk),
		.i_rtc_osc_enable(i_rtc_osc_enable), .i_io_req(i_io_req), .i_io_addr(i_io_addr),
		.o_io_grant(o_io_grant), .o_io_block(o_io_block), .i_clock_output_enable_bit(i_clock_output_enable_bit),
		.i_wake_output_mode(i_wake_output_mode), .i_rtc_alarm_pending(i_rtc_alarm_pending),
		.o_rtc_clock_output_pin(o_rtc_clock_output_pin), .o_rtc_clock_output_pin_oe(o_rtc_clock_output_pin_oe),
		.i_wake_pin(i_wake_pin), .o_wake_pin(o_wake_pin), .o_wake_pin_oe(o_wake_pin_oe),
		.o_core_wake_req(o_core_wake_req), .o_osc_running(o_osc_running));
	rpw_partner rpw_partner_inst (.i_run(i_rtc_osc_enable), .i_low(low), .i_oe(o_wake_pin_oe),
		.o_xtal(i_rtc_xtal_clk), .o_line(i_wake_pin));
	initial forever #2.5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) if (++cyc > 20000) test_done;
	task chk(input logic v, input logic e);
		comparisons++;
		err_count += int'(v !== e);
		if (v !== e) $display("BAD %0t mismatch", $time);
	endtask
	// Drive on a rising edge, sample at the falling edge n cycles on
	task dr(input logic [4:0] c, input logic [16:0] r, input int n);
		@(posedge i_ref_clk);
		ctl <= c;
		rq <= r;
		repeat (n) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask
	task t_pins;
		chk(o_rtc_clock_output_pin_oe, 1'b0);
		dr(5'h08, 17'h0, 3);
		chk(o_rtc_clock_output_pin_oe, 1'b1);
		chk(o_core_wake_req, 1'b1);
		dr(5'h06, 17'h0, 1);
		chk(i_wake_pin, 1'b0);
		dr(5'h04, 17'h0, 3);
		chk(i_wake_pin, 1'b1);
		chk(o_core_wake_req, 1'b0);
		chk(o_wake_pin, 1'b0);
	endtask
	task t_io;
		dr(5'h01, 17'h1197F, 1);
		chk(o_io_block, 1'b1);
		chk(o_io_grant, 1'b0);
		for (int k = 0; k < 7000 && o_osc_running !== 1'b1; k++) dr(5'h11, 17'h0, 0);
		chk(o_osc_running, 1'b1);
		dr(5'h11, 17'h11900, 1);
		chk(o_io_grant, 1'b1);
		chk(o_rtc_clock_output_pin, 1'b0);
		for (int k = 0; k < 7000 && i_rtc_xtal_clk !== 1'b1; k++) dr(5'h19, 17'h0, 0);
		dr(5'h19, 17'h0, 3);
		chk(o_rtc_clock_output_pin, 1'b1);
	endtask
	task test_done;
		err_count += int'(cyc > 20000);
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		@(negedge i_ref_clk);
		t_pins;
		t_io;
		test_done;
	end
endmodule
